// file: rtl/lbc_regs.sv
// Brightness and current register bank for a four-output LED driver.
// Assumes a one-cycle byte write/read request on mclk_i and a start-up
// non-volatile load strobe from the configuration loader.
`timescale 1ns/1ns
`default_nettype none
module lbc_regs (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Register port
  input wire lbc_pkg::lbc_req_t req_i,
  output logic [7:0] rdata_o,
  // Start-up load
  input wire logic nv_load_i,
  input wire lbc_pkg::lbc_nv_t nv_i,
  // Mode and range
  input wire logic out1_display_i,
  input wire logic any_display_i,
  input wire logic [2:0] max_current_range_select_i,
  // Set-points
  output logic [15:0] display_brightness_o,
  output logic [12:0] out1_brightness_o,
  output logic [11:0] display_current_o,
  output logic [11:0] out1_current_o,
  output logic [12:0] out2_brightness_o,
  output logic [7:0] out2_current_o,
  output logic [7:0] full_scale_ma_o,
  output logic [19:0] out1_current_ua_o,
  output logic [15:0] out2_current_ma_scaled_o
);

  // Range decode, shared by every scaled output
  function automatic logic [7:0] range_ma(input logic [2:0] code);
    case (code)
      3'h0: range_ma = lbc_pkg::RANGE_MA_0;
      3'h1: range_ma = lbc_pkg::RANGE_MA_1;
      3'h2: range_ma = lbc_pkg::RANGE_MA_2;
      3'h3: range_ma = lbc_pkg::RANGE_MA_3;
      3'h4: range_ma = lbc_pkg::RANGE_MA_4;
      3'h5: range_ma = lbc_pkg::RANGE_MA_5;
      3'h6: range_ma = lbc_pkg::RANGE_MA_6;
      default: range_ma = lbc_pkg::RANGE_MA_7;
    endcase
  endfunction

  logic wr_brt_hi;
  logic wr_brt_lo;
  logic wr_cur_hi;
  logic wr_cur_lo;
  logic wr_o2b_hi;
  logic wr_o2b_lo;
  logic wr_o2_cur;
  logic [7:0] brt_hi_q;
  logic [7:0] brt_lo_q;
  logic [7:0] cur_hi_q;
  logic [7:0] cur_lo_q;
  logic [7:0] o2b_hi_q;
  logic [7:0] o2b_lo_q;
  logic [7:0] o2_cur_q;
  logic [15:0] brt_act_q;
  logic [11:0] cur_act_q;
  logic [12:0] o2b_act_q;
  logic [7:0] rdata_d;
  logic [7:0] fs_ma;
  logic [11:0] shared_cur;

  // Write strobe decode, one per mapped offset
  function automatic logic wr_hit(input lbc_pkg::lbc_req_t req, input logic [7:0] addr);
    wr_hit = req.wr && (req.addr == addr);
  endfunction

  assign wr_brt_hi = wr_hit(req_i, lbc_pkg::ADDR_BRT_HI);
  assign wr_brt_lo = wr_hit(req_i, lbc_pkg::ADDR_BRT_LO);
  assign wr_cur_hi = wr_hit(req_i, lbc_pkg::ADDR_CUR_HI);
  assign wr_cur_lo = wr_hit(req_i, lbc_pkg::ADDR_CUR_LO);
  assign wr_o2b_hi = wr_hit(req_i, lbc_pkg::ADDR_O2B_HI);
  assign wr_o2b_lo = wr_hit(req_i, lbc_pkg::ADDR_O2B_LO);
  assign wr_o2_cur = wr_hit(req_i, lbc_pkg::ADDR_O2_CUR);

  // Shared brightness byte storage
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      brt_hi_q <= lbc_pkg::RST_ZERO;
      brt_lo_q <= lbc_pkg::RST_ZERO;
    end
    else
    begin
      if (wr_brt_hi)
        brt_hi_q <= req_i.wdata;
      if (wr_brt_lo)
        brt_lo_q <= req_i.wdata;
    end
  end

  // Shared brightness commit
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      brt_act_q <= 16'h0000;
    else if (wr_brt_lo)
      brt_act_q <= {brt_hi_q, req_i.wdata};
  end

  // Shared current bytes; start-up load beats a same-cycle write
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cur_hi_q <= lbc_pkg::RST_ZERO;
      cur_lo_q <= lbc_pkg::RST_ZERO;
    end
    else if (nv_load_i)
    begin
      cur_hi_q <= nv_i.word0 & lbc_pkg::CUR_HI_MASK;
      cur_lo_q <= nv_i.word1;
    end
    else
    begin
      if (wr_cur_hi)
        cur_hi_q <= req_i.wdata & lbc_pkg::CUR_HI_MASK;
      if (wr_cur_lo)
        cur_lo_q <= req_i.wdata;
    end
  end

  // Shared current commit
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cur_act_q <= 12'h000;
    else if (nv_load_i)
      cur_act_q <= {nv_i.word0[3:0], nv_i.word1};
    else if (wr_cur_lo)
      cur_act_q <= {cur_hi_q[3:0], req_i.wdata};
  end

  // Output 2 brightness bytes; reserved high bits read back as zero
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      o2b_hi_q <= lbc_pkg::RST_ZERO;
      o2b_lo_q <= lbc_pkg::RST_ZERO;
    end
    else
    begin
      if (wr_o2b_hi)
        o2b_hi_q <= req_i.wdata & lbc_pkg::O2B_HI_MASK;
      if (wr_o2b_lo)
        o2b_lo_q <= req_i.wdata;
    end
  end

  // Output 2 brightness commit
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      o2b_act_q <= 13'h0;
    else if (wr_o2b_lo)
      o2b_act_q <= {o2b_hi_q[4:0], req_i.wdata};
  end

  // Output 2 current code, no staging needed for a single byte
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      o2_cur_q <= lbc_pkg::RST_ZERO;
    else if (wr_o2_cur)
      o2_cur_q <= req_i.wdata;
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    case (req_i.addr)
      lbc_pkg::ADDR_BRT_HI: rdata_d = brt_hi_q;
      lbc_pkg::ADDR_BRT_LO: rdata_d = brt_lo_q;
      lbc_pkg::ADDR_CUR_HI: rdata_d = cur_hi_q;
      lbc_pkg::ADDR_CUR_LO: rdata_d = cur_lo_q;
      lbc_pkg::ADDR_O2B_HI: rdata_d = o2b_hi_q;
      lbc_pkg::ADDR_O2B_LO: rdata_d = o2b_lo_q;
      lbc_pkg::ADDR_O2_CUR: rdata_d = o2_cur_q;
      default: rdata_d = lbc_pkg::RST_ZERO;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_o <= 8'h00;
    else if (req_i.rd)
      rdata_o <= rdata_d;
  end

  assign fs_ma = range_ma(max_current_range_select_i);
  assign shared_cur = cur_act_q;

  // Full scale registered, one cycle behind the range input
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      full_scale_ma_o <= lbc_pkg::RST_ZERO;
    else
      full_scale_ma_o <= fs_ma;
  end

  // Brightness set-points; the idle side of the mode is held at zero
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      display_brightness_o <= 16'h0000;
      out1_brightness_o <= 13'h0;
    end
    else
    begin
      display_brightness_o <= out1_display_i ? brt_act_q : 16'h0000;
      out1_brightness_o <= out1_display_i ? 13'h0 : brt_act_q[15:3];
    end
  end

  // Shared current set-points
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      display_current_o <= 12'h000;
      out1_current_o <= 12'h000;
    end
    else
    begin
      display_current_o <= any_display_i ? shared_cur : 12'h000;
      out1_current_o <= any_display_i ? 12'h000 : shared_cur;
    end
  end

  // Output 2 set-points
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      out2_brightness_o <= 13'h0;
      out2_current_o <= 8'h00;
    end
    else
    begin
      out2_brightness_o <= o2b_act_q;
      out2_current_o <= o2_cur_q;
    end
  end

  // full-scale scaling, output 1
  // Raw product only; the divide by the code range is left to the analog stage
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      out1_current_ua_o <= 20'h00000;
    else
      out1_current_ua_o <= 20'(shared_cur) * 20'(fs_ma);
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      out2_current_ma_scaled_o <= 16'h0000;
    else
      out2_current_ma_scaled_o <= 16'(o2_cur_q) * 16'(fs_ma);
  end

endmodule // lbc_regs
`default_nettype wire

// file: rtl/lbc_pkg.sv
// Package for the LED brightness and current register bank.
// Assumes a simple byte-wide register port on a single clock.
package lbc_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_BRT_HI = 8'h00;
  localparam logic [7:0] ADDR_BRT_LO = 8'h01;
  localparam logic [7:0] ADDR_CUR_HI = 8'h02;
  localparam logic [7:0] ADDR_CUR_LO = 8'h03;
  localparam logic [7:0] ADDR_O2B_HI = 8'h04;
  localparam logic [7:0] ADDR_O2B_LO = 8'h05;
  localparam logic [7:0] ADDR_O2_CUR = 8'h06;
  // Reset values and field masks
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] CUR_HI_MASK = 8'h0F;
  localparam logic [7:0] O2B_HI_MASK = 8'h1F;
  // Field widths
  localparam int SHARED_BRT_W = 16;
  localparam int CLUSTER_BRT_W = 13;
  localparam int SHARED_CUR_W = 12;
  localparam int OUT2_CUR_W = 8;
  localparam int RANGE_W = 3;
  localparam int MA_W = 8;
  // Range table in milliamps, code 0 to 7
  localparam logic [7:0] RANGE_MA_0 = 8'h19;
  localparam logic [7:0] RANGE_MA_1 = 8'h1E;
  localparam logic [7:0] RANGE_MA_2 = 8'h32;
  localparam logic [7:0] RANGE_MA_3 = 8'h3C;
  localparam logic [7:0] RANGE_MA_4 = 8'h50;
  localparam logic [7:0] RANGE_MA_5 = 8'h64;
  localparam logic [7:0] RANGE_MA_6 = 8'h78;
  localparam logic [7:0] RANGE_MA_7 = 8'h96;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lbc_req_t;

  typedef struct packed {
    logic [7:0] word0;
    logic [7:0] word1;
  } lbc_nv_t;
endpackage

// file: verif/lbc_regs_monitor.sv
// Checker for lbc_regs: commit lag, mode gating, range table codes 0 and 7.
// Assumes it is bound into lbc_regs.
`timescale 1ns/1ns
`default_nettype none
module lbc_regs_monitor (
  // Clock, reset, request
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire lbc_pkg::lbc_req_t req_i,
  // Mode and range
  input wire logic out1_display_i,
  input wire logic any_display_i,
  input wire logic [2:0] max_current_range_select_i,
  // Set-points
  input wire logic [15:0] display_brightness_o,
  input wire logic [12:0] out1_brightness_o,
  input wire logic [11:0] display_current_o,
  input wire logic [11:0] out1_current_o,
  input wire logic [12:0] out2_brightness_o,
  input wire logic [7:0] full_scale_ma_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  // only a low write moves it
  o2b_commit_a: assert property ($changed(out2_brightness_o) |-> $past(req_i.wr && req_i.addr == 8'h05, 2))
    else $error("out2 brightness moved alone");
  disp_off_a: assert property (!out1_display_i |=> display_brightness_o == 16'h0000)
    else $error("display brightness not gated");
  o1b_off_a: assert property (out1_display_i |=> out1_brightness_o == 13'h0000)
    else $error("out1 brightness not gated");
  o1b_hand_a: assert property ((out1_display_i && !req_i.wr) ##1 !out1_display_i |=>
    {out1_brightness_o, 3'h0} == ($past(display_brightness_o) & 16'hFFF8))
    else $error("out1 brightness not top bits");
  dcur_off_a: assert property (!any_display_i |=> display_current_o == 12'h000)
    else $error("display current not gated");
  o1cur_off_a: assert property (any_display_i |=> out1_current_o == 12'h000)
    else $error("out1 current not gated");
  rng_min_a: assert property (max_current_range_select_i == 3'h0 |=> full_scale_ma_o == 8'h19)
    else $error("range 0 wrong");
  rng_max_a: assert property (max_current_range_select_i == 3'h7 |=> full_scale_ma_o == 8'h96)
    else $error("range 7 wrong");
  cover property (req_i.wr && req_i.addr == 8'h01);
  cover property (out1_display_i ##1 !out1_display_i);
  cover property (any_display_i ##1 !any_display_i);
endmodule // lbc_regs_monitor
bind lbc_regs lbc_regs_monitor u_lbc_regs_monitor (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(req_i),
  .out1_display_i(out1_display_i), .any_display_i(any_display_i),
  .max_current_range_select_i(max_current_range_select_i), .display_brightness_o(display_brightness_o),
  .out1_brightness_o(out1_brightness_o), .display_current_o(display_current_o),
  .out1_current_o(out1_current_o), .out2_brightness_o(out2_brightness_o), .full_scale_ma_o(full_scale_ma_o));
`default_nettype wire

// file: verif/testbench.sv
// Bench for lbc_regs: integer model compared at every result.
// Assumes two-edge commit lag and registered read data.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  lbc_pkg::lbc_req_t req_i = '0;
  lbc_pkg::lbc_nv_t nv_i = '0;
  logic nv_load_i = 1'b0, od = 1'b1, ad = 1'b1;
  logic [2:0] rs = 3'h0;
  logic [7:0] rdata_o, fs, o2c;
  logic [15:0] db, o2s;
  logic [12:0] o1b, o2b;
  logic [11:0] dc, o1c;
  logic [19:0] o1s;
  int n_mismatch = 0, compares = 0, m[8], i, a, cb, cc, c2b;
  int ma[8] = '{25, 30, 50, 60, 80, 100, 120, 150};
  // Seed 13275
  logic [31:0] s = 32'h000033DB;
  always #4 mclk_i = ~mclk_i;
  lbc_regs u_lbc_regs (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(req_i), .rdata_o(rdata_o),
    .nv_load_i(nv_load_i), .nv_i(nv_i), .out1_display_i(od), .any_display_i(ad),
    .max_current_range_select_i(rs), .display_brightness_o(db), .out1_brightness_o(o1b),
    .display_current_o(dc), .out1_current_o(o1c), .out2_brightness_o(o2b), .out2_current_o(o2c),
    .full_scale_ma_o(fs), .out1_current_ua_o(o1s), .out2_current_ma_scaled_o(o2s));
  function logic [7:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0];
  endfunction
  task chk(input logic [19:0] g, input logic [19:0] e);
    compares++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Request held for one edge; caller never clears it in the same step
  task op(input logic w, input logic r, input logic [7:0] x, input logic [7:0] d);
    req_i = '{w, r, x, d};
    @(posedge mclk_i);
    #1;
  endtask
  task wr(input int x, input int d);
    op(1'b1, 1'b0, 8'(x), 8'(d));
    if (x < 7) m[x] = d & (x == 2 ? 15 : x == 4 ? 31 : 255);
    if (x == 1) cb = m[0] * 256 + m[1];
    if (x == 3) cc = m[2] * 256 + m[3];
    if (x == 5) c2b = m[4] * 256 + m[5];
  endtask
  task rd(input int x);
    op(1'b0, 1'b1, 8'(x), 8'h00);
    op(1'b0, 1'b0, 8'h00, 8'h00);
    chk(rdata_o, x < 7 ? m[x] : 0);
  endtask
  task sp();
    op(1'b0, 1'b0, 8'h00, 8'h00);
    op(1'b0, 1'b0, 8'h00, 8'h00);
    chk(db, od ? cb : 0);
    chk(o1b, od ? 0 : cb >> 3);
    chk(dc, ad ? cc : 0);
    chk(o1c, ad ? 0 : cc);
    chk(o2b, c2b);
    chk(o2c, m[6]);
    chk(fs, ma[rs]);
    chk(o1s, cc * ma[rs]);
    chk(o2s, m[6] * ma[rs]);
  endtask
  task summarize();
    if (n_mismatch == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    n_mismatch++;
    summarize();
  end
  initial
  begin
    repeat (4) @(posedge mclk_i);
    #1;
    rst_b_i = 1'b1;
    for (i = 0; i < 8; i++) rd(i);
    sp();
    // start-up load of the current pair
    nv_i = {rnd(), rnd()};
    nv_load_i = 1'b1;
    op(1'b0, 1'b0, 8'h00, 8'h00);
    nv_load_i = 1'b0;
    m[2] = nv_i.word0 & 15;
    m[3] = nv_i.word1;
    cc = m[2] * 256 + m[3];
    rd(2);
    rd(3);
    sp();
    repeat (8)
    begin
      for (a = 0; a < 6; a += 2)
      begin
        wr(a, rnd());
        // old value holds until the low byte
        sp();
        wr(a + 1, rnd());
      end
      wr(6, rnd());
      wr(7, rnd());
      wr(0, rnd());
      wr(1, rnd());
      od = rnd() > 127;
      ad = rnd() > 127;
      rs = 3'(rnd());
      // combined value after the low byte
      sp();
      for (i = 0; i < 8; i++) rd(i);
    end
    rst_b_i = 1'b0;
    op(1'b0, 1'b0, 8'h00, 8'h00);
    rst_b_i = 1'b1;
    for (i = 0; i < 8; i++) m[i] = 0;
    cb = 0;
    cc = 0;
    c2b = 0;
    for (i = 0; i < 8; i++) rd(i);
    sp();
    for (i = 0; i < 8; i++)
    begin
      rs = 3'(i);
      od = ~od;
      sp();
    end
    summarize();
  end
endmodule // testbench
`default_nettype wire
